// [timer_core.sv]
// 24-bit down-counting timer with prescaler, preload and zero detect
// Assumes a host on a plain strobe port and an asynchronous timer input pin
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
module timer_core
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // Timer pins
  input  wire logic       i_timer_in_pin,
  output logic            o_timer_out_pin,
  output logic            o_timer_out_oe,
  // Interrupt
  output logic            o_irq
);

  // ========================================================
  // Registers
  logic [7:0]       ctrl_q;
  logic [CNT_W-1:0] preload_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic             zero_detect_flag_q;
  logic             zero_detect_flag_d;
  logic             mask_q;
  logic             loaded_q;
  logic             loaded_d;
  logic             timer_out_pin_q;
  logic             timer_out_pin_d;
  logic             oe_q;
  logic             irq_q;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;

  // ========================================================
  // Timer input synchroniser
  logic tin_level;
  logic tin_rise;
  logic tin_fall;

  timer_edge u_tin
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    (i_timer_in_pin),
    .o_level    (tin_level),
    .o_rise     (tin_rise),
    .o_fall     (tin_fall)
  );

  // ========================================================
  // Control decode
  wire       en_bit      = ctrl_q[CTL_EN];
  wire [1:0] clk_sel     = ctrl_q[CTL_CLK_HI:CTL_CLK_LO];
  wire       wrap_mode   = ctrl_q[CTL_ZD];
  wire [2:0] out_fn      = ctrl_q[CTL_OUT_HI:CTL_OUT_LO];
  wire       ext_clk     = clk_sel[1];
  wire       pre_used    = ~(clk_sel == 2'b11) | 1'b0;
  wire       no_pre      = (clk_sel == 2'b10);
  wire       tin_enable  = (clk_sel == 2'b01);
  wire       out_used    = (out_fn != 3'h0) & (out_fn != 3'h1);
  wire       wdog        = (out_fn == OUT_WDOG) & tin_enable;
  // Run follows the input when used as enable
  wire       run         = en_bit & (tin_enable ? tin_level : 1'b1);
  // Prescaler clocked by core clock or input rising edge
  wire       pre_tick    = run & (ext_clk ? tin_rise : 1'b1) & ~no_pre;
  wire       pre_wrap    = pre_tick & (pre_q == PRE_ZERO);
  // Counter clock from prescaler wrap or direct input edge
  wire       cnt_tick    = run & (no_pre ? tin_rise : pre_wrap);
  wire       hit_zero    = cnt_tick & loaded_q & (cnt_q == CNT_ONE);
  wire       sts_clr     = i_wr & (i_addr == OFS_STATUS) & i_wdata[STS_ZD];

  // ========================================================
  // Prescaler and counter next state
  always_comb
  begin
    pre_d    = pre_q;
    cnt_d    = cnt_q;
    loaded_d = loaded_q;
    if (!run)
    begin
      pre_d    = PRE_ALL1;
      loaded_d = 1'b0;
    end
    else
    begin
      if (pre_tick)
        pre_d = pre_q - 5'h01;
      if (cnt_tick)
      begin
        if (!loaded_q)
        begin
          cnt_d    = preload_q;
          loaded_d = 1'b1;
        end
        else if (cnt_q == CNT_ZERO && !wrap_mode)
          cnt_d = preload_q;
        else
          cnt_d = cnt_q - CNT_ONE;
      end
    end
  end

  // ========================================================
  // Zero-detect flag and timer output
  always_comb
  begin
    zero_detect_flag_d = zero_detect_flag_q;
    timer_out_pin_d             = timer_out_pin_q;
    if (sts_clr)
      zero_detect_flag_d = 1'b0;
    if (hit_zero)
      zero_detect_flag_d = 1'b1;
    if (!run)
      zero_detect_flag_d = 1'b0;
    if (!out_used || !run)
      timer_out_pin_d = 1'b0;
    else
      timer_out_pin_d = zero_detect_flag_d;
  end

  // ========================================================
  // Read mux
  always_comb
  begin
    rdata_d = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        OFS_CTRL:    rdata_d = ctrl_q;
        OFS_PRE_HI:  rdata_d = preload_q[23:16];
        OFS_PRE_MID: rdata_d = preload_q[15:8];
        OFS_PRE_LO:  rdata_d = preload_q[7:0];
        OFS_CNT_HI:  rdata_d = cnt_q[23:16];
        OFS_CNT_MID: rdata_d = cnt_q[15:8];
        OFS_CNT_LO:  rdata_d = cnt_q[7:0];
        OFS_STATUS:  rdata_d = {7'h00, zero_detect_flag_q};
        OFS_MASK:    rdata_d = {7'h00, mask_q};
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  // ========================================================
  // Host-written registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == OFS_CTRL)
        ctrl_q <= i_wdata;
      if (i_addr == OFS_MASK)
        mask_q <= i_wdata[0];
    end
  end

  // Preload is not cleared by reset
  always_ff @(posedge i_core_clk)
  begin
    if (i_wr && i_addr == OFS_PRE_HI)
      preload_q[23:16] <= i_wdata;
    if (i_wr && i_addr == OFS_PRE_MID)
      preload_q[15:8] <= i_wdata;
    if (i_wr && i_addr == OFS_PRE_LO)
      preload_q[7:0] <= i_wdata;
  end

  // ========================================================
  // Timer state
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      cnt_q              <= CNT_ZERO;
      pre_q              <= PRE_ALL1;
      loaded_q           <= 1'b0;
      zero_detect_flag_q <= 1'b0;
      timer_out_pin_q             <= 1'b0;
      oe_q               <= 1'b0;
      irq_q              <= 1'b0;
      rdata_q            <= 8'h00;
    end
    else
    begin
      cnt_q              <= cnt_d;
      pre_q              <= pre_d;
      loaded_q           <= loaded_d;
      zero_detect_flag_q <= zero_detect_flag_d;
      timer_out_pin_q             <= timer_out_pin_d;
      oe_q               <= out_used;
      irq_q              <= zero_detect_flag_d & mask_q;
      rdata_q            <= rdata_d;
    end
  end

  assign o_timer_out_pin = timer_out_pin_q;
  assign o_timer_out_oe  = oe_q;
  assign o_irq           = irq_q;
  assign o_rdata         = rdata_q;

  // Unused decode kept quiet
  wire unused_ok = pre_used & wdog;

endmodule

// [timer_pkg.sv]
// Constants for the 24-bit down-counting timer block
// Assumes a single core clock and a plain strobe register port
package timer_pkg;

  // ==========================================================
  // Widths
  localparam int CNT_W = 24;
  localparam int PRE_W = 5;

  // ==========================================================
  // Register offsets (word index, byte address = 4 * index)
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_PRE_HI  = 5'h01;
  localparam logic [4:0] OFS_PRE_MID = 5'h02;
  localparam logic [4:0] OFS_PRE_LO  = 5'h03;
  localparam logic [4:0] OFS_CNT_HI  = 5'h04;
  localparam logic [4:0] OFS_CNT_MID = 5'h05;
  localparam logic [4:0] OFS_CNT_LO  = 5'h06;
  localparam logic [4:0] OFS_STATUS  = 5'h07;
  localparam logic [4:0] OFS_MASK    = 5'h08;

  // ==========================================================
  // Control field positions
  localparam int CTL_EN      = 0;
  localparam int CTL_CLK_LO  = 1;
  localparam int CTL_CLK_HI  = 2;
  localparam int CTL_ZD      = 4;
  localparam int CTL_OUT_LO  = 5;
  localparam int CTL_OUT_HI  = 7;

  // Status field positions
  localparam int STS_ZD = 0;

  // ==========================================================
  // Reset values and counter compare constants
  localparam logic [7:0]       CTRL_RST = 8'h00;
  localparam logic [0:0]       MASK_RST = 1'h0;
  localparam logic [PRE_W-1:0] PRE_ALL1 = 5'h1F;
  localparam logic [PRE_W-1:0] PRE_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

  // Output function code for the watchdog configuration
  localparam logic [2:0] OUT_WDOG = 3'h5;

endpackage

// [timer_edge.sv]
// Two-flop synchroniser with rising and falling edge detection
// Assumes an asynchronous level input and one core clock
`timescale 1ns/100ps
module timer_edge
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // Asynchronous input
  input  wire logic i_async,
  // Synchronised outputs
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // ========================================================
  // Synchroniser
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;

endmodule

// [timer_application_modes_sva.sv]
// Checker for the timer core ports
// Assumes it is bound onto timer_core
`timescale 1ns/100ps
module timer_chk
  import timer_pkg::*;
(
  // Watched ports
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_timer_in_pin,
  input wire logic       o_timer_out_pin,
  input wire logic       o_timer_out_oe,
  input wire logic       o_irq
);
  // ====
  // Shadow control register and its age
  logic [7:0] ctrl_q;
  logic [1:0] age_q;
  wire        ctl_wr = i_wr && i_addr == OFS_CTRL;
  wire        wdog   = ctrl_q[7:5] == OUT_WDOG && ctrl_q[2:1] == 2'h1;
  always_ff @(posedge i_core_clk)
    ctrl_q <= i_rst ? CTRL_RST : (ctl_wr ? i_wdata : ctrl_q);
  always_ff @(posedge i_core_clk)
    age_q <= (i_rst || ctl_wr) ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ====
  // Assertions
  a_rdata_idle:
  assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero:
  assert property (i_rd && i_addr > OFS_MASK |=> o_rdata == 8'h00) else $error("unmapped read");
  a_status_bits:
  assert property (i_rd && i_addr == OFS_STATUS |=> o_rdata[7:1] == 7'h00) else $error("status");
  a_reset_quiet:
  assert property ($fell(i_rst) |-> !o_irq && !o_timer_out_pin) else $error("active after reset");
  a_halt_quiet:
  assert property (!ctrl_q[CTL_EN] && age_q == 2'h3 |-> !o_irq && !o_timer_out_pin)
    else $error("active while halted");
  a_out_unused:
  assert property (ctrl_q[7:6] == 2'h0 && age_q == 2'h3 |-> !o_timer_out_pin)
    else $error("output without function");
  a_oe_function:
  assert property (age_q == 2'h3 |-> o_timer_out_oe == (ctrl_q[7:6] != 2'h0))
    else $error("output enable wrong");
  a_wdog_quiet:
  assert property ((wdog && !i_timer_in_pin) [*8] |-> !o_timer_out_pin && !o_irq)
    else $error("watchdog active with input low");
  c_irq: cover property ($rose(o_irq));
  c_out: cover property ($rose(o_timer_out_pin));
  c_unmapped: cover property (i_rd && i_addr > OFS_MASK);
endmodule
bind timer_core timer_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_timer_in_pin(i_timer_in_pin), .o_timer_out_pin(o_timer_out_pin),
  .o_timer_out_oe(o_timer_out_oe), .o_irq(o_irq));

// [timer_in_src.sv]
// Source of the external timer input: a level or a burst of pulses
// Assumes the core clock; pulses are 4 high and 4 low
`timescale 1ns/100ps
module timer_in_src
(
  // Clock and controls
  input  wire logic       i_core_clk,
  input  wire logic       i_level,
  input  wire logic [7:0] i_pulses,
  input  wire logic       i_go,
  // Timer input pin
  output logic            o_timer_in_pin
);
  logic [7:0] left_q = 8'h00;
  logic [2:0] ph_q   = 3'h0;
  always @(posedge i_core_clk)
  begin
    // Restart the phase on go so every burst holds whole pulses only
    ph_q <= i_go ? 3'h0 : ph_q + 3'h1;
    if (i_go)
      left_q <= i_pulses;
    else if (ph_q == 3'h7 && left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  assign o_timer_in_pin = (left_q != 8'h00) ? (ph_q < 3'h4) : i_level;
endmodule

// [timer_application_modes_tb.sv]
// Self-checking bench for the timer core
// Assumes timer_in_src drives the timer input pin
`timescale 1ns/100ps
module timer_application_modes_tb import timer_pkg::*;;
  // ====
  // Signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        lvl = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  pulses = 8'h00;
  logic [7:0]  rdata, b;
  logic [23:0] v;
  logic        pin, out, oe, irq;
  int          n;
  int          err_count = 0;
  int          total_checks = 0;
  always #2 clk = ~clk;
  timer_core uut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
    .i_rd(rd_s), .o_rdata(rdata), .i_timer_in_pin(pin), .o_timer_out_pin(out),
    .o_timer_out_oe(oe), .o_irq(irq));
  timer_in_src src (.i_core_clk(clk), .i_level(lvl), .i_pulses(pulses), .i_go(go),
    .o_timer_in_pin(pin));
  // ====
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pre(input logic [23:0] p);
    reg_wr(OFS_PRE_HI, p[23:16]);
    reg_wr(OFS_PRE_MID, p[15:8]);
    reg_wr(OFS_PRE_LO, p[7:0]);
  endtask
  task automatic cnt(output logic [23:0] c);
    reg_rd(OFS_CNT_HI, c[23:16]);
    reg_rd(OFS_CNT_MID, c[15:8]);
    reg_rd(OFS_CNT_LO, c[7:0]);
  endtask
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      k++;
    end
    if (irq !== 1'b1)
    begin
      err_count++;
      give_verdict();
    end
  endtask
  // ====
  // Tests
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reg_rd(OFS_STATUS, b); chk("status", b, 0);
    reg_wr(OFS_CNT_LO, 8'h5A);
    cnt(v); chk("count", v, 0);
    reg_rd(5'h1F, b); chk("unmapped", b, 0);
    $display("reset test done");
    reg_wr(OFS_MASK, 8'h01);
    pre(24'h000003);
    reg_wr(OFS_CTRL, 8'h10);
    reg_wr(OFS_CTRL, 8'h11);
    wait_irq(300, n); chk("zero time", 24'(n >= 120 && n <= 136), 1);
    repeat (36) @(posedge clk);
    reg_rd(OFS_STATUS, b); chk("latched", b, 1);
    reg_wr(OFS_CTRL, 8'h10);
    cnt(v); chk("wrap", v, 24'hFFFFFF);
    reg_rd(OFS_STATUS, b); chk("halted", b, 0);
    $display("elapsed test done");
    pre(24'h000002);
    reg_wr(OFS_CTRL, 8'h40);
    reg_wr(OFS_CTRL, 8'h41);
    wait_irq(300, n); chk("timeout", 24'(n >= 88 && n <= 104), 1);
    #1 chk("out", out, 1);
    reg_wr(OFS_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("clear", irq, 0);
    reg_wr(OFS_CTRL, 8'h00);
    $display("timeout test done");
    pre(24'h00000A);
    reg_wr(OFS_CTRL, 8'h15);
    pulses <= 8'h05;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (60) @(posedge clk);
    reg_wr(OFS_CTRL, 8'h14);
    cnt(v); chk("pulses", v, 24'h000006);
    $display("pulse test done");
    pre(24'h000002);
    reg_wr(OFS_CTRL, 8'hB3);
    repeat (20) @(posedge clk);
    lvl <= 1'b1;
    repeat (45) @(posedge clk);
    lvl <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("early drop", {irq, out}, 0);
    cnt(v); chk("loaded", v, 24'h000002);
    lvl <= 1'b1;
    wait_irq(200, n);
    #1 chk("late out", out, 1);
    lvl <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("fall", {irq, out}, 0);
    reg_rd(OFS_STATUS, b); chk("fall flag", b, 0);
    $display("watchdog test done");
    pre(24'hFFFFFF);
    reg_wr(OFS_CTRL, 8'h11);
    repeat (98) @(posedge clk);
    reg_wr(OFS_CTRL, 8'h10);
    cnt(v); chk("all ones", v, 24'hFFFFFD);
    $display("all ones test done");
    give_verdict();
  end
endmodule
